// [logic/autoneg_ability_registers.sv]
// Auto-negotiation advertisement and link-partner ability registers with APB access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "autoneg_defs.svh"

module autoneg_ability_registers #(
  parameter int MATCH_COUNT = `AN_MATCH_COUNT
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Link side
  input  wire logic                 restartNeg,
  input  wire logic                 rxPageValid,
  input  wire autoneg_pkg::anPage_s rxPage,
  output autoneg_pkg::anPage_s      txPage,
  output logic                      nextPageEnable,
  output logic                      autonegEnable,
  // Interrupt
  output logic                      irq
);

  // ==========================================================
  // State
  autoneg_pkg::apbState_e  apbState_q;
  logic                    npStored_q;
  logic                    ack_q;
  logic                    remoteFault_q;
  logic [7:0]              tech_q;
  logic [4:0]              selector_q;
  autoneg_pkg::anPage_s    partner_q;
  logic [1:0]              config_q;
  logic [`AN_IRQ_BITS-1:0] irqStatus_q;
  logic [`AN_IRQ_BITS-1:0] irqMask_q;
  logic                    pageSeen_q;

  logic                    accValid;
  autoneg_pkg::anPage_s    accPage;
  logic                    legacyMode;
  logic                    npEffective;
  logic                    bsrRemoteFault;
  logic                    wrStrobe;
  logic                    rdStrobe;
  logic [`AN_IRQ_BITS-1:0] irqEvents;
  logic [15:0]             advWord;
  logic [15:0]             wdata16;
  logic [15:0]             rdWord;
  logic                    advWrite;
  logic                    cfgWrite;
  logic                    irqStWrite;
  logic                    irqMskWrite;
  logic                    irqPending;

  // ==========================================================
  // Address decode
  function automatic logic hitIndex(input logic [31:0] addr, input logic [7:0] idx);
    hitIndex = (addr == {22'h0, idx, 2'h0});
  endfunction

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hitIndex(addr, `AN_IDX_BASIC_STATUS) || hitIndex(addr, `AN_IDX_ADVERTISE)
             || hitIndex(addr, `AN_IDX_PARTNER) || hitIndex(addr, `AN_IDX_CONFIG)
             || hitIndex(addr, `AN_IDX_IRQ_STATUS) || hitIndex(addr, `AN_IDX_IRQ_MASK);
  endfunction

  function automatic logic [15:0] packPage(input autoneg_pkg::anPage_s pg);
    packPage = {pg.nextPage, pg.ack, pg.remoteFault, pg.tech, pg.selector};
  endfunction

  // The T4 technology is unsupported, so a written one is dropped
  function automatic logic [7:0] techMask(input logic [7:0] t);
    techMask              = t;
    techMask[`AN_TECH_T4] = 1'b0;
  endfunction

  // ==========================================================
  // Derived values
  assign legacyMode     = config_q[`AN_CFG_LEGACY];
  assign npEffective    = npStored_q && !legacyMode;
  assign bsrRemoteFault = partner_q.remoteFault && config_q[`AN_CFG_AN_ENABLE];
  assign wdata16        = pwdata[15:0];
  // A write lands only on the edge that the master sees pready
  assign wrStrobe       = psel && penable && pwrite && pready;
  assign rdStrobe       = psel && penable && !pwrite && apbState_q == autoneg_pkg::APB_IDLE;
  assign advWord        = {npEffective, ack_q, remoteFault_q, tech_q, selector_q};
  assign advWrite       = wrStrobe && hitIndex(paddr, `AN_IDX_ADVERTISE);
  assign cfgWrite       = wrStrobe && hitIndex(paddr, `AN_IDX_CONFIG);
  assign irqStWrite     = wrStrobe && hitIndex(paddr, `AN_IDX_IRQ_STATUS);
  assign irqMskWrite    = wrStrobe && hitIndex(paddr, `AN_IDX_IRQ_MASK);
  assign irqPending     = |(irqStatus_q & irqMask_q);

  // ==========================================================
  // Received page consistency check
  page_match_filter #(
    .MATCH_COUNT (MATCH_COUNT)
  ) u_match (
    .clk      (clk),
    .reset    (reset),
    .restart  (restartNeg),
    .rxValid  (rxPageValid),
    .rxPage   (rxPage),
    .accValid (accValid),
    .accPage  (accPage)
  );

  // ==========================================================
  // APB phase: one wait state, then pready for one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      apbState_q <= autoneg_pkg::APB_IDLE;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      case (apbState_q)
        autoneg_pkg::APB_IDLE: begin
          if (psel && penable) begin
            apbState_q <= autoneg_pkg::APB_ANSWER;
            pready     <= 1'b1;
            pslverr    <= !mapped(paddr);
          end
        end
        autoneg_pkg::APB_ANSWER: begin
          apbState_q <= autoneg_pkg::APB_IDLE;
          pready     <= 1'b0;
          pslverr    <= 1'b0;
        end
        default: begin
          apbState_q <= autoneg_pkg::APB_IDLE;
          pready     <= 1'b0;
          pslverr    <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Read multiplexer; unmapped offsets read as zero
  always_comb begin
    rdWord = 16'h0000;
    if (hitIndex(paddr, `AN_IDX_BASIC_STATUS)) begin
      rdWord[`AN_BSR_REMOTE_FAULT] = bsrRemoteFault;
    end
    if (hitIndex(paddr, `AN_IDX_ADVERTISE)) begin
      rdWord = advWord;
    end
    if (hitIndex(paddr, `AN_IDX_PARTNER)) begin
      rdWord = packPage(partner_q);
    end
    if (hitIndex(paddr, `AN_IDX_CONFIG)) begin
      rdWord[1:0] = config_q;
    end
    if (hitIndex(paddr, `AN_IDX_IRQ_STATUS)) begin
      rdWord[`AN_IRQ_BITS-1:0] = irqStatus_q;
    end
    if (hitIndex(paddr, `AN_IDX_IRQ_MASK)) begin
      rdWord[`AN_IRQ_BITS-1:0] = irqMask_q;
    end
  end

  // ==========================================================
  // Read data, captured together with pready
  // The word stands only with pready, so no stale value lingers after the answer
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (rdStrobe) begin
      prdata <= {16'h0000, rdWord};
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // Advertisement register writes
  // Legacy mode freezes the stored next-page bit rather than clearing it
  always_ff @(posedge clk) begin
    if (reset) begin
      npStored_q <= 1'b0;
    end else if (advWrite && !legacyMode) begin
      npStored_q <= wdata16[`AN_BIT_NEXT_PAGE];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      remoteFault_q <= 1'b0;
    end else if (advWrite) begin
      remoteFault_q <= wdata16[`AN_BIT_REMOTE_FAULT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tech_q <= `AN_TECH_RESET;
    end else if (advWrite) begin
      tech_q <= techMask(wdata16[`AN_TECH_MSB:`AN_TECH_LSB]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      selector_q <= `AN_SEL_RESET;
    end else if (advWrite) begin
      selector_q <= wdata16[`AN_SEL_MSB:`AN_SEL_LSB];
    end
  end

  // ==========================================================
  // Local acknowledge: set when the partner page proves consistent
  always_ff @(posedge clk) begin
    if (reset || restartNeg) begin
      ack_q <= 1'b0;
    end else if (accValid) begin
      ack_q <= 1'b1;
    end
  end

  // ==========================================================
  // Partner register, loaded only from an accepted page
  always_ff @(posedge clk) begin
    if (reset || restartNeg) begin
      partner_q <= '0;
    end else if (accValid) begin
      partner_q <= accPage;
    end
  end

  // ==========================================================
  // Configuration register
  always_ff @(posedge clk) begin
    if (reset) begin
      config_q <= `AN_CFG_RESET;
    end else if (cfgWrite) begin
      config_q <= wdata16[1:0];
    end
  end

  // ==========================================================
  // Interrupt events
  // Remote fault raises an event on its rising edge only
  always_ff @(posedge clk) begin
    if (reset) begin
      pageSeen_q <= 1'b0;
    end else begin
      pageSeen_q <= bsrRemoteFault;
    end
  end

  always_comb begin
    irqEvents = '0;
    irqEvents[`AN_IRQ_PAGE]         = accValid;
    irqEvents[`AN_IRQ_REMOTE_FAULT] = bsrRemoteFault && !pageSeen_q;
    irqEvents[`AN_IRQ_ACK]          = accValid && accPage.ack;
  end

  // ==========================================================
  // Interrupt status, sticky, write one to clear
  // Set beats the write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irqStatus_q <= '0;
    end else begin
      if (irqStWrite) begin
        irqStatus_q <= (irqStatus_q & ~wdata16[`AN_IRQ_BITS-1:0]) | irqEvents;
      end else begin
        irqStatus_q <= irqStatus_q | irqEvents;
      end
    end
  end

  // ==========================================================
  // Interrupt mask and level output
  always_ff @(posedge clk) begin
    if (reset) begin
      irqMask_q <= '0;
    end else if (irqMskWrite) begin
      irqMask_q <= wdata16[`AN_IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irqPending;
    end
  end

  // ==========================================================
  // Link outputs, registered copies of the advertisement and of the configuration enable bit
  always_ff @(posedge clk) begin
    if (reset) begin
      txPage <= '0;
    end else begin
      txPage.nextPage    <= npEffective;
      txPage.ack         <= ack_q;
      txPage.remoteFault <= remoteFault_q;
      txPage.tech        <= tech_q;
      txPage.selector    <= selector_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nextPageEnable <= 1'b0;
    end else begin
      nextPageEnable <= npEffective;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      autonegEnable <= 1'b0;
    end else begin
      autonegEnable <= config_q[`AN_CFG_AN_ENABLE];
    end
  end

endmodule

// [logic/autoneg_defs.svh]
// Register indices, field positions, reset values and counts of the ability register bank
`ifndef AUTONEG_DEFS_SVH
`define AUTONEG_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define AN_IDX_BASIC_STATUS   8'h01
`define AN_IDX_ADVERTISE      8'h04
`define AN_IDX_PARTNER        8'h05
`define AN_IDX_CONFIG         8'h1C
`define AN_IDX_IRQ_STATUS     8'h1D
`define AN_IDX_IRQ_MASK       8'h1E

// ==========================================================
// Page field positions
`define AN_BIT_NEXT_PAGE      15
`define AN_BIT_ACK            14
`define AN_BIT_REMOTE_FAULT   13
`define AN_TECH_MSB           12
`define AN_TECH_LSB           5
`define AN_SEL_MSB            4
`define AN_SEL_LSB            0

// Technology field bit positions inside the eight-bit field
`define AN_TECH_PAUSE         5
`define AN_TECH_T4            4

// ==========================================================
// Configuration and status fields
`define AN_CFG_LEGACY         0
`define AN_CFG_AN_ENABLE      1
`define AN_BSR_REMOTE_FAULT   4
`define AN_IRQ_PAGE           0
`define AN_IRQ_REMOTE_FAULT   1
`define AN_IRQ_ACK            2
`define AN_IRQ_BITS           3

// ==========================================================
// Reset values
`define AN_TECH_RESET         8'h0F
`define AN_SEL_RESET          5'h01
`define AN_CFG_RESET          2'h2

// ==========================================================
// Identical pages needed before a received page is accepted
`define AN_MATCH_COUNT        3

`endif

// [logic/autoneg_pkg.sv]
// Types shared by the ability register bank
package autoneg_pkg;

  // ==========================================================
  // One sixteen-bit base page as exchanged on the link
  typedef struct packed {
    logic       nextPage;
    logic       ack;
    logic       remoteFault;
    logic [7:0] tech;
    logic [4:0] selector;
  } anPage_s;

  // ==========================================================
  // APB slave phase
  typedef enum {
    APB_IDLE,
    APB_ANSWER
  } apbState_e;

endpackage

// [logic/page_match_filter.sv]
// Accepts a received page only after it arrives unchanged several times in a row
`timescale 1ns/1ps
`include "autoneg_defs.svh"

module page_match_filter #(
  parameter int MATCH_COUNT = `AN_MATCH_COUNT
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Restart clears the history
  input  wire logic              restart,
  // Raw pages from the link
  input  wire logic              rxValid,
  input  wire autoneg_pkg::anPage_s rxPage,
  // Accepted page
  output logic                   accValid,
  output autoneg_pkg::anPage_s   accPage
);

  localparam int CW = $clog2(MATCH_COUNT + 1);

  autoneg_pkg::anPage_s lastPage_q;
  logic [CW-1:0]        count_q;
  logic                 done_q;

  // ==========================================================
  // Consistency tracking
  // A mismatch restarts the count, so a noisy page never lands
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      lastPage_q <= '0;
      count_q    <= '0;
      done_q     <= 1'b0;
    end else if (rxValid) begin
      lastPage_q <= rxPage;
      if (count_q != '0 && rxPage == lastPage_q) begin
        if (count_q != CW'(MATCH_COUNT)) begin
          count_q <= count_q + CW'(1);
        end
      end else begin
        count_q <= CW'(1);
        done_q  <= 1'b0;
      end
      if (count_q == CW'(MATCH_COUNT - 1) && rxPage == lastPage_q) begin
        done_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Acceptance pulse, once per run of identical pages
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      accValid <= 1'b0;
      accPage  <= '0;
    end else begin
      accValid <= rxValid && !done_q && rxPage == lastPage_q
                  && count_q == CW'(MATCH_COUNT - 1);
      if (rxValid) begin
        accPage <= rxPage;
      end
    end
  end

endmodule

// [tb/autoneg_ability_registers_assertions.sv]
// Port checker for the ability register bank
`timescale 1ns/1ps

module autoneg_ability_registers_assertions #(
  parameter int MATCH_COUNT = 3
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Link and interrupt
  input wire logic                 restartNeg,
  input wire logic                 rxPageValid,
  input wire autoneg_pkg::anPage_s rxPage,
  input wire autoneg_pkg::anPage_s txPage,
  input wire logic                 nextPageEnable,
  input wire logic                 autonegEnable,
  input wire logic                 irq
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_three;
    rxPageValid ##1 (rxPageValid && $stable(rxPage))[*2];
  endsequence
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_answer; psel && penable && !pready |=> pready; endproperty
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  property p_rdata_idle; prdata[31:16] == 16'h0000 && (pready || prdata == 32'h0); endproperty
  property p_t4_zero; !txPage.tech[4]; endproperty
  property p_np_follow; $changed(nextPageEnable) |-> ##[0:2] (txPage.nextPage == nextPageEnable); endproperty
  property p_tx_reset; $fell(reset) |-> ##[1:2] (txPage == 16'h01E1); endproperty
  property p_ack; s_three |-> ##[1:4] txPage.ack; endproperty
  property p_legacy_np;
    psel && penable && pwrite && pready && paddr == 32'h00000070 && pwdata[0] |=> ##1 !nextPageEnable;
  endproperty

  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_answer: assert property (p_ready_answer) else $error("pready late");
  a_err_ready: assert property (p_err_ready) else $error("pslverr outside answer");
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  a_t4_zero: assert property (p_t4_zero) else $error("T4 advertised");
  a_np_follow: assert property (p_np_follow) else $error("next page bit wrong");
  a_tx_reset: assert property (p_tx_reset) else $error("advert reset value");
  a_ack: assert property (p_ack) else $error("ack not set");
  a_legacy_np: assert property (p_legacy_np) else $error("next page enabled in legacy mode");
  c_err: cover property (pslverr);
  c_ack: cover property ($rose(txPage.ack));
  c_irq: cover property ($rose(irq));
endmodule

bind autoneg_ability_registers autoneg_ability_registers_assertions #(.MATCH_COUNT(MATCH_COUNT)) u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .restartNeg(restartNeg),
  .rxPageValid(rxPageValid), .rxPage(rxPage), .txPage(txPage), .nextPageEnable(nextPageEnable),
  .autonegEnable(autonegEnable), .irq(irq));

// [tb/link_partner_model.sv]
// Far-end partner that repeats one base page
`timescale 1ns/1ps

module link_partner_model #(
  parameter int REPEAT = 3
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset,
  // Command
  input wire logic                 go,
  input wire logic                 slow,
  input wire autoneg_pkg::anPage_s page,
  output logic                     busy,
  // Link
  output logic                     rxPageValid,
  output autoneg_pkg::anPage_s     rxPage
);
  // ==========================================================
  // Sender
  int cnt;
  int gap;
  assign busy = (cnt != 0);
  // In slow mode the line toggles between pages so stale data never looks valid
  always @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      gap <= 0;
      rxPageValid <= 1'b0;
      rxPage <= '0;
    end else if (go) begin
      cnt <= REPEAT;
      gap <= 0;
    end else if (cnt != 0 && gap == 0) begin
      rxPageValid <= 1'b1;
      rxPage <= page;
      cnt <= cnt - 1;
      gap <= slow ? 3 : 0;
    end else begin
      rxPageValid <= 1'b0;
      rxPage <= ~rxPage;
      if (gap != 0) gap <= gap - 1;
    end
  end
endmodule

// [tb/autoneg_ability_registers_tb.sv]
// Register and page tests of the ability register bank
`timescale 1ns/1ps

module autoneg_ability_registers_tb;
  // ==========================================================
  // Signals
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic restartNeg = 0, go = 0, slow = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdVal;
  logic pready, pslverr, rxPageValid, nextPageEnable, autonegEnable, irq, busy, rdErr;
  autoneg_pkg::anPage_s rxPage, txPage;
  autoneg_pkg::anPage_s lpPage = '0;
  int err_total = 0, checks = 0;

  always #2 clk = ~clk;

  autoneg_ability_registers u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .restartNeg(restartNeg), .rxPageValid(rxPageValid), .rxPage(rxPage),
    .txPage(txPage), .nextPageEnable(nextPageEnable), .autonegEnable(autonegEnable), .irq(irq));
  link_partner_model u_lp (.clk(clk), .reset(reset), .go(go), .slow(slow), .page(lpPage),
    .busy(busy), .rxPageValid(rxPageValid), .rxPage(rxPage));

  // ==========================================================
  // Tasks
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      results();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdVal[15:0], exp);
  endtask
  task automatic page(input logic [15:0] p, input logic s);
    int n;
    n = 0;
    lpPage <= p; slow <= s; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_total++;
      results();
    end
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk("txRst", txPage, 16'h01E1);
    chk("anRst", 16'(autonegEnable), 16'h0001);
    rdc("advRst", 32'h10, 16'h01E1);
    rdc("lpRst", 32'h14, 16'h0000);
    $display("reset test done");
    wr(32'h10, 32'hFFFF);
    rdc("advAll", 32'h10, 16'hBDFF);
    chk("txAll", txPage, 16'hBDFF);
    chk("npEn", 16'(nextPageEnable), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      wr(32'h10, 32'h1 | (32'h20 << i));
      rdc("tech", 32'h10, (i == 4) ? 16'h0001 : (16'h0001 | (16'h0020 << i)));
    end
    $display("field test done");
    wr(32'h10, 32'h8001);
    wr(32'h70, 32'h3);
    rdc("advLeg", 32'h10, 16'h0001);
    chk("npLeg", 16'(nextPageEnable), 16'h0000);
    wr(32'h10, 32'h0001);
    wr(32'h70, 32'h2);
    rdc("advRet", 32'h10, 16'h8001);
    chk("npRet", 16'(nextPageEnable), 16'h0001);
    wr(32'h10, 32'h21E1);
    repeat (2) @(posedge clk);
    chk("txRf", txPage, 16'h21E1);
    $display("legacy test done");
    wr(32'h78, 32'h7);
    page(16'hF4A1, 1'b0);
    chk("irqOn", 16'(irq), 16'h0001);
    rdc("lpPage", 32'h14, 16'hF4A1);
    rdc("bsrRf", 32'h04, 16'h0010);
    rdc("irqSt", 32'h74, 16'h0007);
    chk("txAck", txPage, 16'h61E1);
    wr(32'h70, 32'h0);
    rdc("bsrOff", 32'h04, 16'h0000);
    chk("anOff", 16'(autonegEnable), 16'h0000);
    wr(32'h70, 32'h2);
    wr(32'h74, 32'h7);
    rdc("irqClr", 32'h74, 16'h0000);
    chk("irqOff", 16'(irq), 16'h0000);
    wr(32'h78, 32'h0);
    page(16'h01E1, 1'b1);
    chk("irqMsk", 16'(irq), 16'h0000);
    rdc("lpSlow", 32'h14, 16'h01E1);
    rdc("irqSt2", 32'h74, 16'h0001);
    wr(32'h78, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqUnm", 16'(irq), 16'h0001);
    wr(32'h74, 32'h1);
    repeat (2) @(posedge clk);
    chk("irqW1c", 16'(irq), 16'h0000);
    $display("page test done");
    restartNeg <= 1'b1;
    @(posedge clk);
    restartNeg <= 1'b0;
    repeat (3) @(posedge clk);
    rdc("lpRstrt", 32'h14, 16'h0000);
    rdc("advRstrt", 32'h10, 16'h21E1);
    apb(1'b0, 32'h40, 32'h0);
    chk("errFlag", 16'(rdErr), 16'h0001);
    chk("errData", rdVal[15:0], 16'h0000);
    wr(32'h14, 32'hFFFF);
    rdc("lpRo", 32'h14, 16'h0000);
    $display("access test done");
    wr(32'h10, 32'h8001);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk("txRst2", txPage, 16'h01E1);
    rdc("advRst2", 32'h10, 16'h01E1);
    $display("midrun reset test done");
    results();
  end
endmodule
